/* rtl/acs_defs.vh */
// constants for the conversion sequencer
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH
`define ACS_ADDR_PAIR_CFG 8'hba
`define ACS_ADDR_CHAN_SEL 8'hbb
`define ACS_ADDR_CONV_CFG 8'hbc
`define ACS_ADDR_RESULT 8'hbe
`define ACS_ADDR_CONV_CTRL 8'he8
`define ACS_RST_PAIR_CFG 8'h00
`define ACS_RST_CHAN_SEL 8'h00
`define ACS_RST_CONV_CFG 8'hf8
`define ACS_RST_CONV_CTRL 8'h00
`define ACS_RST_RESULT 8'h00
`define ACS_CTL_EN 7
`define ACS_CTL_TM 6
`define ACS_CTL_DONE 5
`define ACS_CTL_BUSY 4
`define ACS_CTL_CM2 3
`define ACS_CTL_CM0 1
`define ACS_CTL_WINT 0
`define ACS_CM_SOFT 3'h0
`define ACS_CM_TMR3 3'h1
`define ACS_CM_EXT 3'h2
`define ACS_CM_TMR2 3'h3
`define ACS_TRACK_CLKS 4'h3
`define ACS_CONV_CLKS 4'h8
`define ACS_SAR_MAX_KHZ 6000
`define ACS_SETTLE_NS 800
`define ACS_SYS_KHZ 25000
`define ACS_SETTLE_CYC ((`ACS_SETTLE_NS * `ACS_SYS_KHZ + 999999) / 1000000)
`endif

/* rtl/acs_sar_core.v */
// successive-approximation bit sequencer
`timescale 1ns/10ps
module acs_sar_core #(
   parameter WIDTH = 8
) (
   input wire I_MCLK,
   input wire I_NRST,
   input wire i_start,
   input wire i_tick,
   input wire i_cmp_hi,
   input wire i_signed,
   output wire o_busy,
   output reg o_done,
   output reg [WIDTH-1:0] o_trial,
   output reg [WIDTH-1:0] o_result
);
   reg [WIDTH-1:0] mask;
   reg active;
   assign o_busy = active;
   always @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         mask <= {WIDTH{1'b0}};
         active <= 1'b0;
         o_done <= 1'b0;
         o_trial <= {WIDTH{1'b0}};
         o_result <= {WIDTH{1'b0}};
      end else begin
         o_done <= 1'b0;
         if (i_start && !active) begin
            active <= 1'b1;
            mask <= {1'b1, {(WIDTH-1){1'b0}}};
            o_trial <= {1'b1, {(WIDTH-1){1'b0}}};
         end else if (active && i_tick) begin
            // keep the trial bit when the input is above the trial level
            if (mask == {{(WIDTH-1){1'b0}}, 1'b1}) begin
               active <= 1'b0;
               o_done <= 1'b1;
               // offset binary to two's complement for differential pairs
               o_result <= i_signed ?
                  {~o_trial[WIDTH-1], o_trial[WIDTH-2:1], i_cmp_hi} :
                  {o_trial[WIDTH-1:1], i_cmp_hi};
            end else begin
               mask <= mask >> 1;
               o_trial <= (o_trial & ~(mask & {WIDTH{~i_cmp_hi}})) | (mask >> 1);
            end
         end
      end
   end
endmodule // acs_sar_core

/* rtl/acs_sequencer.v */
// second converter control: mux, gain, sar clock, start sources, tracking
// Operation
// - eight inputs chosen by 3-bit channel address
// - gain 0.5/1/2/4, resets to 0.5
// - sar clock divided from system clock
// - one start source chosen by start mode
// - busy high throughout conversion, then cleared
// - busy fall sets done flag, interrupt
// - result register loaded at completion
// - sibling busy write starts both converters
// - normal mode tracks except while converting
// - low-power mode tracks three sar clocks first, except external start
// - external start: track low, convert rising
// - tracking stops in chip standby or sleep
// - pair config upper four bits read zero
// - pair bits join even/odd inputs differential
// - differential results are two's complement
// - channel select upper five bits read zero
// - even address routes differential pair
// - gain code 00..11 means 0.5..4
// - sar clock is system clock over field+1
// - start mode encoding 000..1xx
// - done flag cleared only by software
`timescale 1ns/10ps
`include "acs_defs.vh"
module acs_sequencer #(
   parameter WIDTH = 8
) (
   input wire I_MCLK,
   input wire I_NRST,
   input wire [7:0] I_SFR_ADDR,
   input wire [7:0] I_SFR_WDATA,
   input wire I_SFR_WR,
   output reg [7:0] O_SFR_RDATA,
   input wire I_TMR3_OVF,
   input wire I_TMR2_OVF,
   input wire I_SIBLING_BUSY_WR,
   input wire I_EXT_START,
   input wire I_CHIP_SLEEP,
   input wire I_CMP_HI,
   output wire [2:0] O_MUX_POS,
   output wire [2:0] O_MUX_NEG,
   output wire O_MUX_DIFF,
   output wire [1:0] O_GAIN,
   output wire O_TRACK,
   output wire O_ANALOG_EN,
   output wire [WIDTH-1:0] O_DAC_TRIAL,
   output wire O_SAR_CLK,
   output wire O_CONV_IRQ
);
   localparam ST_IDLE = 2'h0;
   localparam ST_TRACK = 2'h1;
   localparam ST_CONV = 2'h2;
   localparam [7:0] RST_PAIR = `ACS_RST_PAIR_CFG;
   localparam [7:0] RST_SEL = `ACS_RST_CHAN_SEL;
   localparam [7:0] RST_CFG = `ACS_RST_CONV_CFG;
   localparam [7:0] RST_CTRL = `ACS_RST_CONV_CTRL;

   reg [3:0] pair_cfg;
   reg [2:0] chan_sel;
   reg [4:0] clk_div;
   reg [1:0] gain;
   reg en;
   reg track_mode;
   reg done_flag;
   reg wint_flag;
   reg [2:0] start_mode;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [4:0] div_cnt;
   reg sar_clk;
   reg [3:0] trk_cnt;
   reg [2:0] lat_chan;
   reg lat_diff;
   reg [1:0] lat_gain;
   reg ext_s1;
   reg ext_s2;
   reg ext_d;
   reg busy_d;
   reg src_evt;
   wire sar_tick;
   wire ext_rise;
   wire soft_start;
   wire start_evt;
   wire core_busy;
   wire core_done;
   wire [WIDTH-1:0] core_result;
   wire busy;
   wire sel_diff;
   wire [3:0] pair_hit;
   wire conv_go;

   // control and config register writes
   always @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         pair_cfg <= RST_PAIR[3:0];
         chan_sel <= RST_SEL[2:0];
         clk_div <= RST_CFG[7:3];
         gain <= RST_CFG[1:0];
         en <= RST_CTRL[`ACS_CTL_EN];
         track_mode <= RST_CTRL[`ACS_CTL_TM];
         start_mode <= RST_CTRL[`ACS_CTL_CM2:`ACS_CTL_CM0];
         wint_flag <= RST_CTRL[`ACS_CTL_WINT];
      end else if (I_SFR_WR) begin
         if (I_SFR_ADDR == `ACS_ADDR_PAIR_CFG) begin
            pair_cfg <= I_SFR_WDATA[3:0];
         end else if (I_SFR_ADDR == `ACS_ADDR_CHAN_SEL) begin
            chan_sel <= I_SFR_WDATA[2:0];
         end else if (I_SFR_ADDR == `ACS_ADDR_CONV_CFG) begin
            clk_div <= I_SFR_WDATA[7:3];
            gain <= I_SFR_WDATA[1:0];
         end else if (I_SFR_ADDR == `ACS_ADDR_CONV_CTRL) begin
            en <= I_SFR_WDATA[`ACS_CTL_EN];
            track_mode <= I_SFR_WDATA[`ACS_CTL_TM];
            start_mode <= I_SFR_WDATA[`ACS_CTL_CM2:`ACS_CTL_CM0];
            wint_flag <= I_SFR_WDATA[`ACS_CTL_WINT];
         end
      end
   end

   // done flag: hardware set wins over a software clear
   always @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         done_flag <= 1'b0;
      end else if (busy_d && !busy) begin
         done_flag <= 1'b1;
      end else if (I_SFR_WR && I_SFR_ADDR == `ACS_ADDR_CONV_CTRL) begin
         done_flag <= I_SFR_WDATA[`ACS_CTL_DONE];
      end
   end

   // sar clock: system clock over (field + 1), max 6 MHz is software's choice
   always @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         div_cnt <= 5'h00;
         sar_clk <= 1'b0;
      end else if (div_cnt >= clk_div) begin
         div_cnt <= 5'h00;
         sar_clk <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 5'h01;
         sar_clk <= (div_cnt < {1'b0, clk_div[4:1]});
      end
   end
   assign sar_tick = (div_cnt >= clk_div);
   assign O_SAR_CLK = sar_clk;

   // external start pin synchroniser
   always @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         // idle level of the pin, so release of reset shows no edge
         ext_s1 <= 1'b1;
         ext_s2 <= 1'b1;
         ext_d <= 1'b1;
         busy_d <= 1'b0;
      end else begin
         ext_s1 <= I_EXT_START;
         ext_s2 <= ext_s1;
         ext_d <= ext_s2;
         busy_d <= busy;
      end
   end
   assign ext_rise = ext_s2 && !ext_d;

   assign soft_start = I_SFR_WR && (I_SFR_ADDR == `ACS_ADDR_CONV_CTRL) &&
                       I_SFR_WDATA[`ACS_CTL_BUSY];
   // start source multiplexer
   always @* begin
      case (start_mode)
         `ACS_CM_SOFT: begin
            src_evt = soft_start;
         end
         `ACS_CM_TMR3: begin
            src_evt = I_TMR3_OVF;
         end
         `ACS_CM_EXT: begin
            src_evt = ext_rise;
         end
         `ACS_CM_TMR2: begin
            src_evt = I_TMR2_OVF;
         end
         default: begin
            src_evt = I_SIBLING_BUSY_WR;
         end
      endcase
   end
   // a start while the core still runs is dropped
   assign start_evt = en && src_evt && !core_busy;

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_evt) begin
               // external edge in low-power mode converts at once
               if (track_mode && start_mode != `ACS_CM_EXT) begin
                  next_state = ST_TRACK;
               end else begin
                  next_state = ST_CONV;
               end
            end
         end
         ST_TRACK: begin
            if (sar_tick && trk_cnt == `ACS_TRACK_CLKS - 4'h1) begin
               next_state = ST_CONV;
            end
         end
         ST_CONV: begin
            if (core_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (!en) begin
         next_state = ST_IDLE;
      end
   end

   always @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state <= ST_IDLE;
         trk_cnt <= 4'h0;
         lat_chan <= 3'h0;
         lat_diff <= 1'b0;
         lat_gain <= 2'h0;
      end else begin
         state <= next_state;
         if (state == ST_TRACK && sar_tick) begin
            trk_cnt <= trk_cnt + 4'h1;
         end else if (state != ST_TRACK) begin
            trk_cnt <= 4'h0;
         end
         // settings follow registers until conversion, then hold
         if (state == ST_IDLE || state == ST_TRACK) begin
            lat_chan <= chan_sel;
            lat_diff <= sel_diff;
            lat_gain <= gain;
         end
      end
   end

   // differential when pair bit set and even address chosen
   genvar p;
   generate
      for (p = 0; p < 4; p = p + 1) begin : g_pair
         localparam [2:0] EVEN_ADDR = p * 2;
         assign pair_hit[p] = pair_cfg[p] && (chan_sel == EVEN_ADDR);
      end
   endgenerate
   assign sel_diff = |pair_hit;
   assign O_MUX_POS = lat_chan;
   assign O_MUX_NEG = {lat_chan[2:1], 1'b1};
   assign O_MUX_DIFF = lat_diff;
   assign O_GAIN = lat_gain;
   assign O_ANALOG_EN = en;
   // tracking windows per mode
   assign O_TRACK = en && !I_CHIP_SLEEP && (state != ST_CONV) &&
                    (!track_mode || state == ST_TRACK ||
                     (start_mode == `ACS_CM_EXT && !ext_s2));

   assign busy = (state == ST_TRACK) || (state == ST_CONV) || core_busy;
   // one-cycle launch, so the core cannot restart while its done is seen
   assign conv_go = (state != ST_CONV) && (next_state == ST_CONV);

   acs_sar_core #(
      .WIDTH(WIDTH)
   ) u_core (
      .I_MCLK(I_MCLK),
      .I_NRST(I_NRST),
      .i_start(conv_go),
      .i_tick(sar_tick),
      .i_cmp_hi(I_CMP_HI),
      .i_signed(lat_diff),
      .o_busy(core_busy),
      .o_done(core_done),
      .o_trial(O_DAC_TRIAL),
      .o_result(core_result)
   );

   assign O_CONV_IRQ = done_flag;

   // register read mux
   always @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_SFR_RDATA <= 8'h00;
      end else if (I_SFR_ADDR == `ACS_ADDR_PAIR_CFG) begin
         O_SFR_RDATA <= {4'h0, pair_cfg};
      end else if (I_SFR_ADDR == `ACS_ADDR_CHAN_SEL) begin
         O_SFR_RDATA <= {5'h00, chan_sel};
      end else if (I_SFR_ADDR == `ACS_ADDR_CONV_CFG) begin
         O_SFR_RDATA <= {clk_div, 1'b0, gain};
      end else if (I_SFR_ADDR == `ACS_ADDR_CONV_CTRL) begin
         O_SFR_RDATA <= {en, track_mode, done_flag, busy, start_mode, wint_flag};
      end else if (I_SFR_ADDR == `ACS_ADDR_RESULT) begin
         O_SFR_RDATA <= core_result;
      end else begin
         O_SFR_RDATA <= 8'h00;
      end
   end
endmodule // acs_sequencer

/* tb/acs_props.sv */
// port assertions for the conversion sequencer
`timescale 1ns/10ps
module acs_props (
   input wire I_MCLK,
   input wire I_NRST,
   input wire [7:0] I_SFR_ADDR,
   input wire [7:0] I_SFR_WDATA,
   input wire I_SFR_WR,
   input wire [7:0] O_SFR_RDATA,
   input wire I_CHIP_SLEEP,
   input wire [2:0] O_MUX_POS,
   input wire [2:0] O_MUX_NEG,
   input wire O_MUX_DIFF,
   input wire [1:0] O_GAIN,
   input wire O_TRACK,
   input wire O_ANALOG_EN,
   input wire O_CONV_IRQ
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_NRST);
   wire wr_ctl = I_SFR_WR && I_SFR_ADDR == 8'he8;
   a_sleep_no_track: assert property (I_CHIP_SLEEP |-> !O_TRACK)
      else $error("tracking while asleep");
   a_done_sticky: assert property (O_CONV_IRQ && !(wr_ctl && !I_SFR_WDATA[5]) |=> O_CONV_IRQ)
      else $error("done flag lost");
   a_busy_fall_done: assert property (I_SFR_ADDR == 8'he8 && $past(I_SFR_ADDR) == 8'he8
      && $past(I_SFR_ADDR, 2) == 8'he8 && $fell(O_SFR_RDATA[4]) |-> ##[0:2] O_CONV_IRQ)
      else $error("no done flag after busy fell");
   a_enable_bit: assert property (wr_ctl |=> O_ANALOG_EN == $past(I_SFR_WDATA[7]))
      else $error("enable not taken");
   a_gain_reset: assert property ($rose(I_NRST) |-> O_GAIN == 2'h0)
      else $error("gain not reset");
   a_pair_upper: assert property (I_SFR_ADDR == 8'hba |=> O_SFR_RDATA[7:4] == 4'h0)
      else $error("pair upper bits set");
   a_sel_upper: assert property (I_SFR_ADDR == 8'hbb |=> O_SFR_RDATA[7:3] == 5'h00)
      else $error("select upper bits set");
   a_diff_routing: assert property (O_MUX_DIFF |-> !O_MUX_POS[0] && O_MUX_NEG == O_MUX_POS + 3'h1)
      else $error("bad differential routing");
   cover property (O_MUX_DIFF);
   cover property ($rose(O_CONV_IRQ));
   cover property (I_CHIP_SLEEP && O_ANALOG_EN);
endmodule // acs_props

/* tb/acs_far_side.sv */
// far side model: analog source, comparator and external start pin
`timescale 1ns/10ps
module acs_far_side (
   input wire i_clk,
   input wire [7:0] i_trial,
   input wire [7:0] i_level,
   input wire i_signed,
   input wire i_go,
   output wire o_cmp_hi,
   output reg o_ext
);
   reg [2:0] low_cnt = 3'h0;
   // trial code is offset binary; a differential level is shifted by half scale
   assign o_cmp_hi = i_signed ? ((i_level ^ 8'h80) >= i_trial) : (i_level >= i_trial);
   initial o_ext = 1'b1;
   // pin pulled low to track, released high to start
   always @(posedge i_clk) begin
      if (i_go) begin
         o_ext <= 1'b0;
         low_cnt <= 3'h6;
      end else if (low_cnt != 3'h0) begin
         low_cnt <= low_cnt - 3'h1;
         o_ext <= low_cnt == 3'h1;
      end
   end
endmodule // acs_far_side

/* tb/tb.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`include "acs_defs.vh"
module tb;
   reg clk, nrst, wr, t3, t2, sib, sleep, go, sgn;
   reg [7:0] addr, wd, lvl, ctl;
   reg [31:0] seed;
   reg [3:0] pc;
   reg [2:0] ch, m;
   integer miscompares, n_checks, i, k;
   wire [7:0] rd, trial;
   wire [2:0] mp;
   wire [1:0] gn;
   wire cmp, ext, md, trk, irq, sclk;
   time t0;
   acs_sequencer u_acs_sequencer (.I_MCLK(clk), .I_NRST(nrst), .I_SFR_ADDR(addr),
      .I_SFR_WDATA(wd), .I_SFR_WR(wr), .O_SFR_RDATA(rd), .I_TMR3_OVF(t3), .I_TMR2_OVF(t2),
      .I_SIBLING_BUSY_WR(sib), .I_EXT_START(ext), .I_CHIP_SLEEP(sleep), .I_CMP_HI(cmp),
      .O_MUX_POS(mp), .O_MUX_NEG(), .O_MUX_DIFF(md), .O_GAIN(gn), .O_TRACK(trk),
      .O_ANALOG_EN(), .O_DAC_TRIAL(trial), .O_SAR_CLK(sclk), .O_CONV_IRQ(irq));
   acs_far_side u_acs_far_side (.i_clk(clk), .i_trial(trial), .i_level(lvl),
      .i_signed(sgn), .i_go(go), .o_cmp_hi(cmp), .o_ext(ext));
   function [31:0] xs(input [31:0] v);
      reg [31:0] x;
      begin
         x = v ^ (v << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction
   function exp_diff(input [3:0] p, input [2:0] c);
      exp_diff = p[c[2:1]] & ~c[0];
   endfunction
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wreg(input [7:0] a, input [7:0] d);
      begin
         @(negedge clk);
         {addr, wd, wr} = {a, d, 1'b1};
         @(negedge clk);
         {addr, wr} = {8'he8, 1'b0};
      end
   endtask
   task rreg(input [7:0] a, input [7:0] exp);
      begin
         @(negedge clk);
         addr = a;
         @(negedge clk);
         chk(rd, exp);
         addr = 8'he8;
      end
   endtask
   task start(input [2:0] s);
      begin
         if (s == 3'h0)
            wreg(8'he8, ctl | 8'h10);
         else begin
            @(negedge clk);
            {t3, t2, go, sib} = {s == 3'h1, s == 3'h3, s == 3'h2, s[2]};
            @(negedge clk);
            {t3, t2, go, sib} = 4'h0;
         end
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #800000;
      miscompares = miscompares + 1;
      conclude;
   end
   initial begin
      {wr, t3, t2, sib, sleep, go, sgn, nrst} = 8'h00;
      {addr, wd, lvl, ctl} = 32'he8000000;
      seed = 32'd82;
      miscompares = 0;
      n_checks = 0;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      rreg(`ACS_ADDR_PAIR_CFG, `ACS_RST_PAIR_CFG);
      rreg(`ACS_ADDR_CHAN_SEL, `ACS_RST_CHAN_SEL);
      rreg(`ACS_ADDR_CONV_CFG, `ACS_RST_CONV_CFG);
      rreg(`ACS_ADDR_CONV_CTRL, `ACS_RST_CONV_CTRL);
      rreg(`ACS_ADDR_RESULT, `ACS_RST_RESULT);
      $display("test reset values done");
      for (i = 0; i < 12; i = i + 1) begin
         seed = xs(seed);
         m = (i < 5) ? i[2:0] : seed[2:0];
         {pc, ch, lvl} = seed[14:0];
         sgn = exp_diff(pc, ch);
         wreg(8'hba, {seed[31:28], pc});
         rreg(8'hba, {4'h0, pc});
         wreg(8'hbb, {seed[23:19], ch});
         rreg(8'hbb, {5'h0, ch});
         wreg(8'hbc, {seed[26:24] + 5'h4, 1'b0, seed[28:27]});
         @(posedge sclk);
         t0 = $time;
         @(posedge sclk);
         chk(8'(($time - t0) / 40), 8'(seed[26:24] + 5));
         ctl = {1'b1, seed[29], 2'h0, m, 1'h0};
         wreg(8'he8, ctl);
         repeat (`ACS_SETTLE_CYC) @(negedge clk);
         start(m);
         if (m != 3'h2) begin
            if (seed[29])
               repeat (4 * (seed[26:24] + 5)) @(negedge clk);
            wreg(8'hbb, {5'h0, ~ch});
            @(negedge clk);
            chk({5'h0, mp}, {5'h0, ch});
            chk({7'h0, md}, {7'h0, sgn});
            chk({6'h0, gn}, {6'h0, seed[28:27]});
         end
         for (k = 0; k < 3000 && irq !== 1'b1; k = k + 1)
            @(negedge clk);
         chk({7'h0, irq}, 8'h01);
         rreg(8'hbe, lvl);
         rreg(8'he8, ctl | 8'h20);
         $display("test conversion %0d done", i);
      end
      ctl = 8'h82;
      wreg(8'he8, ctl);
      for (i = 0; i < 5; i = i + 1)
         if (i != 1)
            start(i[2:0]);
      repeat (100) @(negedge clk);
      rreg(8'he8, ctl);
      $display("test wrong source done");
      sleep = 1'b1;
      @(negedge clk);
      chk({7'h0, trk}, 8'h00);
      sleep = 1'b0;
      @(negedge clk);
      chk({7'h0, trk}, 8'h01);
      $display("test sleep done");
      conclude;
   end
endmodule // tb
bind acs_sequencer acs_props u_acs_props (.I_MCLK(I_MCLK), .I_NRST(I_NRST),
   .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WDATA(I_SFR_WDATA), .I_SFR_WR(I_SFR_WR),
   .O_SFR_RDATA(O_SFR_RDATA), .I_CHIP_SLEEP(I_CHIP_SLEEP), .O_MUX_POS(O_MUX_POS),
   .O_MUX_NEG(O_MUX_NEG), .O_MUX_DIFF(O_MUX_DIFF), .O_GAIN(O_GAIN), .O_TRACK(O_TRACK),
   .O_ANALOG_EN(O_ANALOG_EN), .O_CONV_IRQ(O_CONV_IRQ));
